/* File: verilog/qwc_pkg.sv */
// Constants, pin carrier and phase type for the quad wiper control front end.
// Assumes one 100 MHz clock; all pins arrive asynchronously and are synchronised in the top.
//
// Contract
// - Four channels, each with one volatile wiper and four stored positions, all readable.
// - A wiper position is eight bits, choosing one of 256 taps.
// - Each wiper output always shows its channel's volatile position.
// - After reset, each channel's first stored position is copied into its wiper.
// - Serial data is sampled on each rising serial clock edge.
// - Read data changes only after a falling serial clock edge, one bit per period.
// - The data line is only pulled low or released, never driven high.
// - Respond only when the three low slave address bits match the strap pins.
// - With chip select low, step via clock and direction and ignore the bus.
// - With chip select high, the 2-wire bus interface is enabled.
// - Up/down steps apply only to the channel the two select pins name.
// - With write protect low, every write to stored positions is refused.
// - One serial clock input times both the bus and the up/down port.

package qwc_pkg;

    // ************************************************************
    // Sizes and values
    // ************************************************************
    localparam int         NUM_CH      = 4;
    localparam int         NUM_STORE   = 4;
    localparam int         WIPER_W     = 8;
    localparam logic [7:0] WIPER_MAX   = 8'hFF;
    localparam logic [7:0] WIPER_MIN   = 8'h00;
    localparam logic [7:0] WIPER_ONE   = 8'h01;
    localparam logic [7:0] WIPER_RESET = 8'h00;
    localparam logic [7:0] STORE_RESET = 8'h80;
    localparam logic [1:0] DEFAULT_IDX = 2'h0;

    // ************************************************************
    // Serial framing
    // ************************************************************
    // Upper five slave address bits: arbitrary value
    localparam logic [4:0] ADDR_ID_HI = 5'h0A;
    localparam logic [3:0] ACK_BIT    = 4'h8;
    localparam logic [3:0] BIT_ONE    = 4'h1;
    localparam logic [3:0] BIT_ZERO   = 4'h0;
    localparam logic [3:0] BIT_TOP    = 4'h7;
    localparam int         ID_HI      = 7;
    localparam int         ID_LO      = 3;
    localparam int         STRAP_HI   = 2;
    localparam int         STRAP_LO   = 0;
    localparam int         OP_HI      = 1;
    localparam int         OP_LO      = 0;
    localparam int         CH_HI      = 3;
    localparam int         CH_LO      = 2;
    localparam int         IDX_HI     = 1;
    localparam int         IDX_LO     = 0;
    localparam logic [1:0] OP_RD_WIPER = 2'h0;
    localparam logic [1:0] OP_WR_WIPER = 2'h1;
    localparam logic [1:0] OP_RD_STORE = 2'h2;
    localparam logic [1:0] OP_WR_STORE = 2'h3;

    // ************************************************************
    // Pin carrier and phases
    // ************************************************************
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       cs_n;
        logic       dir_up;
        logic [1:0] sel;
        logic       wp_n;
        logic [2:0] strap;
    } qwc_pins_t;

    // Idle levels: clock, data and chip select high
    localparam qwc_pins_t PINS_RESET = 10'h380;

    typedef enum {PH_IDLE, PH_ADDR, PH_OPC, PH_REG, PH_WDAT, PH_RDAT} qwc_phase_t;

endpackage

/* File: verilog/qwc_top.sv */
// Quad wiper control front end: 2-wire slave, up/down port, wiper and stored position registers.
// Assumes an external pull-up on the data line and an outside master on the serial clock.
`timescale 1ns/1ps
`default_nettype none

module qwc_top (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // 2-wire bus
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Up/down port
    input  wire logic       cs_n,
    input  wire logic       dir_up,
    input  wire logic       chan_sel_lo,
    input  wire logic       chan_sel_hi,
    // Configuration straps
    input  wire logic       wp_n,
    input  wire logic       addr_strap_0,
    input  wire logic       addr_strap_1,
    input  wire logic       addr_strap_2,
    // Wiper taps
    output logic [7:0]      wiper_out_0,
    output logic [7:0]      wiper_out_1,
    output logic [7:0]      wiper_out_2,
    output logic [7:0]      wiper_out_3
);

    // ************************************************************
    // Pin synchroniser and edges
    // ************************************************************
    qwc_pkg::qwc_pins_t pins_raw;
    qwc_pkg::qwc_pins_t sync1_q;
    qwc_pkg::qwc_pins_t pins_s;
    qwc_pkg::qwc_pins_t pins_d;

    assign pins_raw = {scl, sda_i, cs_n, dir_up, chan_sel_hi, chan_sel_lo, wp_n,
                       addr_strap_2, addr_strap_1, addr_strap_0};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= qwc_pkg::PINS_RESET;
            pins_s  <= qwc_pkg::PINS_RESET;
            pins_d  <= qwc_pkg::PINS_RESET;
        end else begin
            sync1_q <= pins_raw;
            pins_s  <= sync1_q;
            pins_d  <= pins_s;
        end
    end

    wire scl_rise = pins_s.scl & ~pins_d.scl;
    wire scl_fall = ~pins_s.scl & pins_d.scl;
    wire start_w  = pins_s.scl & pins_d.scl & ~pins_s.sda & pins_d.sda;
    wire stop_w   = pins_s.scl & pins_d.scl & pins_s.sda & ~pins_d.sda;
    wire bus_en   = pins_s.cs_n;
    wire cs_rise  = pins_s.cs_n & ~pins_d.cs_n;
    wire ud_step  = ~pins_s.cs_n & ~pins_d.cs_n & scl_rise;
    wire [1:0] ud_sel = pins_s.sel;
    wire ud_store = cs_rise & pins_s.scl & pins_s.wp_n;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] wiper_q [qwc_pkg::NUM_CH];
    logic [7:0] store_q [qwc_pkg::NUM_CH][qwc_pkg::NUM_STORE];
    logic       recall_reg;

    qwc_pkg::qwc_phase_t phase_reg, phase_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] out_reg, out_next;
    logic [1:0] op_reg, op_next;
    logic [1:0] chan_reg, chan_next;
    logic [1:0] idx_reg, idx_next;
    logic       sda_oe_reg, oe_next;
    logic       sda_o_reg;
    logic       wr_wiper, wr_store;

    function automatic logic [7:0] step_fn(input logic [7:0] v, input logic up);
        if (up)
            step_fn = (v == qwc_pkg::WIPER_MAX) ? v : v + qwc_pkg::WIPER_ONE;
        else
            step_fn = (v == qwc_pkg::WIPER_MIN) ? v : v - qwc_pkg::WIPER_ONE;
    endfunction

    // ************************************************************
    // Serial decode
    // ************************************************************
    wire addr_match = (shift_reg[qwc_pkg::ID_HI:qwc_pkg::ID_LO] == qwc_pkg::ADDR_ID_HI) &&
                      (shift_reg[qwc_pkg::STRAP_HI:qwc_pkg::STRAP_LO] == pins_s.strap);
    wire byte_done  = scl_rise && (bit_cnt_reg == qwc_pkg::ACK_BIT);
    wire [1:0] reg_ch  = shift_reg[qwc_pkg::CH_HI:qwc_pkg::CH_LO];
    wire [1:0] reg_idx = shift_reg[qwc_pkg::IDX_HI:qwc_pkg::IDX_LO];
    wire op_store   = (op_reg == qwc_pkg::OP_RD_STORE) || (op_reg == qwc_pkg::OP_WR_STORE);
    wire op_read    = (op_reg == qwc_pkg::OP_RD_WIPER) || (op_reg == qwc_pkg::OP_RD_STORE);
    wire [7:0] rd_data = op_store ? store_q[reg_ch][reg_idx] : wiper_q[reg_ch];
    wire [2:0] out_bit = 3'(qwc_pkg::BIT_TOP - bit_cnt_reg);
    wire ack_low    = (bit_cnt_reg == qwc_pkg::ACK_BIT) && (phase_reg != qwc_pkg::PH_RDAT) &&
                      ((phase_reg != qwc_pkg::PH_ADDR) || addr_match);
    wire data_low   = (phase_reg == qwc_pkg::PH_RDAT) && (bit_cnt_reg != qwc_pkg::ACK_BIT) &&
                      !out_reg[out_bit];
    wire store_wr   = wr_store & pins_s.wp_n;

    always_comb begin
        phase_next   = phase_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next   = shift_reg;
        out_next     = out_reg;
        op_next      = op_reg;
        chan_next    = chan_reg;
        idx_next     = idx_reg;
        oe_next      = sda_oe_reg;
        wr_wiper     = 1'b0;
        wr_store     = 1'b0;
        if (!bus_en) begin
            phase_next   = qwc_pkg::PH_IDLE;
            bit_cnt_next = qwc_pkg::BIT_ZERO;
            oe_next      = 1'b0;
        end else if (start_w) begin
            phase_next   = qwc_pkg::PH_ADDR;
            bit_cnt_next = qwc_pkg::BIT_ZERO;
            oe_next      = 1'b0;
        end else if (stop_w) begin
            phase_next   = qwc_pkg::PH_IDLE;
            oe_next      = 1'b0;
        end else if (phase_reg != qwc_pkg::PH_IDLE) begin
            if (scl_rise && (bit_cnt_reg != qwc_pkg::ACK_BIT)) begin
                shift_next   = {shift_reg[6:0], pins_s.sda};
                bit_cnt_next = bit_cnt_reg + qwc_pkg::BIT_ONE;
            end else if (byte_done) begin
                bit_cnt_next = qwc_pkg::BIT_ZERO;
                unique case (phase_reg)
                    qwc_pkg::PH_IDLE: begin
                    end
                    qwc_pkg::PH_ADDR: begin
                        phase_next = addr_match ? qwc_pkg::PH_OPC : qwc_pkg::PH_IDLE;
                    end
                    qwc_pkg::PH_OPC: begin
                        op_next    = shift_reg[qwc_pkg::OP_HI:qwc_pkg::OP_LO];
                        phase_next = qwc_pkg::PH_REG;
                    end
                    qwc_pkg::PH_REG: begin
                        chan_next  = reg_ch;
                        idx_next   = reg_idx;
                        out_next   = rd_data;
                        phase_next = op_read ? qwc_pkg::PH_RDAT : qwc_pkg::PH_WDAT;
                    end
                    qwc_pkg::PH_WDAT: begin
                        wr_wiper = (op_reg == qwc_pkg::OP_WR_WIPER);
                        wr_store = (op_reg == qwc_pkg::OP_WR_STORE);
                    end
                    qwc_pkg::PH_RDAT: begin
                        phase_next = pins_s.sda ? qwc_pkg::PH_IDLE : qwc_pkg::PH_RDAT;
                    end
                endcase
            end else if (scl_fall) begin
                oe_next = ack_low | data_low;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg   <= qwc_pkg::PH_IDLE;
            bit_cnt_reg <= qwc_pkg::BIT_ZERO;
            shift_reg   <= qwc_pkg::WIPER_RESET;
            out_reg     <= qwc_pkg::WIPER_RESET;
            op_reg      <= qwc_pkg::OP_RD_WIPER;
            chan_reg    <= 2'h0;
            idx_reg     <= 2'h0;
            sda_oe_reg  <= 1'b0;
            sda_o_reg   <= 1'b0;
            recall_reg  <= 1'b1;
        end else begin
            phase_reg   <= phase_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg   <= shift_next;
            out_reg     <= out_next;
            op_reg      <= op_next;
            chan_reg    <= chan_next;
            idx_reg     <= idx_next;
            sda_oe_reg  <= oe_next;
            sda_o_reg   <= 1'b0;
            recall_reg  <= 1'b0;
        end
    end

    // ************************************************************
    // Wiper and stored position channels
    // ************************************************************
    for (genvar g = 0; g < qwc_pkg::NUM_CH; g++) begin : g_ch
        wire sel_g = (ud_sel == 2'(g));
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n)
                wiper_q[g] <= qwc_pkg::WIPER_RESET;
            else if (recall_reg)
                wiper_q[g] <= store_q[g][qwc_pkg::DEFAULT_IDX];
            else if (wr_wiper && (chan_reg == 2'(g)))
                wiper_q[g] <= shift_reg;
            else if (ud_step && sel_g)
                wiper_q[g] <= step_fn(wiper_q[g], pins_s.dir_up);
        end
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                for (int j = 0; j < qwc_pkg::NUM_STORE; j++)
                    store_q[g][j] <= qwc_pkg::STORE_RESET;
            end else if (store_wr && (chan_reg == 2'(g))) begin
                store_q[g][idx_reg] <= shift_reg;
            end else if (ud_store && sel_g) begin
                store_q[g][qwc_pkg::DEFAULT_IDX] <= wiper_q[g];
            end
        end
    end

    assign wiper_out_0 = wiper_q[0];
    assign wiper_out_1 = wiper_q[1];
    assign wiper_out_2 = wiper_q[2];
    assign wiper_out_3 = wiper_q[3];
    assign sda_o       = sda_o_reg;
    assign sda_oe      = sda_oe_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence inc_ch0_s;
        ud_step && pins_s.dir_up && (ud_sel == 2'h0) && (wiper_q[0] != qwc_pkg::WIPER_MAX);
    endsequence
    sequence dec_ch0_floor_s;
        ud_step && !pins_s.dir_up && (ud_sel == 2'h0) && (wiper_q[0] == qwc_pkg::WIPER_MIN);
    endsequence

    recall_copy_a:   assert property ($fell(recall_reg) |-> wiper_q[1] == $past(store_q[1][0]))
        else $error("wiper not recalled from default store");
    tap_follow_a:    assert property (ud_step && pins_s.dir_up && (ud_sel == 2'h2) && !recall_reg &&
                                      (wiper_q[2] != qwc_pkg::WIPER_MAX)
                                      |=> wiper_out_2 == $past(wiper_out_2) + 8'h01)
        else $error("wiper output did not follow a step");
    drive_low_a:     assert property (sda_o == 1'b0)
        else $error("data line driven high");
    oe_on_fall_a:    assert property ($rose(sda_oe) |-> $past(scl_fall))
        else $error("data line changed without a falling clock");
    shift_on_rise_a: assert property ($changed(shift_reg) |-> $past(scl_rise))
        else $error("data sampled off the rising clock");
    addr_match_a:    assert property ((phase_reg == qwc_pkg::PH_OPC) && $past(phase_reg == qwc_pkg::PH_ADDR)
                                      |-> $past(shift_reg[qwc_pkg::STRAP_HI:qwc_pkg::STRAP_LO])
                                          == $past(pins_s.strap))
        else $error("slave responded to wrong address");
    cs_low_idle_a:   assert property (!pins_s.cs_n |=> (phase_reg == qwc_pkg::PH_IDLE) && !sda_oe)
        else $error("bus active while chip select low");
    step_inc_a:      assert property (inc_ch0_s and !recall_reg |=> wiper_q[0] == $past(wiper_q[0]) + 8'h01)
        else $error("increment did not move one tap");
    step_floor_a:    assert property (dec_ch0_floor_s and !recall_reg and !wr_wiper |=> wiper_q[0] == 8'h00)
        else $error("decrement wrapped below zero");
    chan_only_a:     assert property (ud_step && (ud_sel != 2'h1) && !wr_wiper && !recall_reg
                                      |=> $stable(wiper_q[1]))
        else $error("unselected channel stepped");
    wp_block_a:      assert property (!pins_s.wp_n |=> $stable(store_q[2][1]))
        else $error("stored position written under protect");
    no_step_cs_a:    assert property (pins_s.cs_n && !wr_wiper && !recall_reg |=> $stable(wiper_q[3]))
        else $error("step committed with chip select high");

endmodule // qwc_top

`default_nettype wire

/* File: test/qwc_master.sv */
// Behavioural 2-wire master and up/down controller for the quad wiper front end.
// Assumes the bench resolves the open-drain data line and feeds it back as sda_line.
`timescale 1ns/1ps
`default_nettype none

module qwc_master (
    // Reference clock and resolved data line
    input  wire logic              ref_clk,
    input  wire logic              sda_line,
    // Pins towards the device
    output var qwc_pkg::qwc_pins_t pins
);
    initial pins = qwc_pkg::PINS_RESET;

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic set_cfg(input logic wp, input logic [2:0] strap);
        pins.wp_n  <= wp;
        pins.strap <= strap;
    endtask

    // ************************************************************
    // 2-wire bus: data moves while the clock is low
    // ************************************************************
    task automatic bit_io(input logic b, output logic r);
        pins.sda <= b;
        tick(5);
        pins.scl <= 1'h1;
        tick(3);
        r = sda_line;
        tick(3);
        pins.scl <= 1'h0;
        tick(1);
    endtask

    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(1'h1, ack);
    endtask

    task automatic frame(input logic [7:0] adr, input logic [1:0] op, input logic [3:0] rg,
                         input logic [7:0] wd, output logic [7:0] rd, output logic [3:0] acks);
        logic [7:0] junk;
        rd = 8'h00;
        pins.sda <= 1'h0;
        tick(6);
        pins.scl <= 1'h0;
        tick(1);
        byte_io(adr, junk, acks[3]);
        byte_io({6'h00, op}, junk, acks[2]);
        byte_io({4'h0, rg}, junk, acks[1]);
        if (op[0]) byte_io(wd, junk, acks[0]);
        else byte_io(8'hFF, rd, acks[0]);
        pins.sda <= 1'h0;
        tick(5);
        pins.scl <= 1'h1;
        tick(6);
        pins.sda <= 1'h1;
        tick(6);
    endtask

    // ************************************************************
    // Up/down port: store leaves the clock high as select rises
    // ************************************************************
    task automatic ud_hold(input logic on);
        pins.cs_n   <= ~on;
        pins.dir_up <= 1'h0;
        pins.sel    <= 2'h0;
        tick(6);
    endtask

    task automatic steps(input logic up, input logic [1:0] ch, input int n, input logic store);
        pins.scl    <= 1'h0;
        pins.cs_n   <= 1'h0;
        pins.dir_up <= up;
        pins.sel    <= ch;
        for (int i = 0; i < n; i++) begin
            tick(6);
            pins.scl <= 1'h1;
            tick(6);
            if (!(store && i == n - 1)) pins.scl <= 1'h0;
        end
        tick(6);
        pins.cs_n <= 1'h1;
        tick(6);
        pins.scl <= 1'h1;
        tick(6);
    endtask
endmodule // qwc_master

`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the quad wiper front end, driven by the master model.
// Assumes the design package is compiled first; the data line has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic               ref_clk;
    logic               rst_n;
    qwc_pkg::qwc_pins_t pins;
    logic               sda_o;
    logic               sda_oe;
    logic               oe_prev;
    logic               scl_prev;
    logic [7:0]         wo [4];
    logic [7:0]         adr;
    logic [7:0]         rd;
    logic [3:0]         acks;
    int                 fails;
    int                 n_checks;
    wire logic          sda_line;

    assign sda_line = ~((sda_oe & ~sda_o) | ~pins.sda);

    qwc_master pm (.ref_clk(ref_clk), .sda_line(sda_line), .pins(pins));
    qwc_top uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl(pins.scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .cs_n(pins.cs_n), .dir_up(pins.dir_up), .chan_sel_lo(pins.sel[0]), .chan_sel_hi(pins.sel[1]),
        .wp_n(pins.wp_n), .addr_strap_0(pins.strap[0]), .addr_strap_1(pins.strap[1]),
        .addr_strap_2(pins.strap[2]), .wiper_out_0(wo[0]), .wiper_out_1(wo[1]), .wiper_out_2(wo[2]),
        .wiper_out_3(wo[3])
    );

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic xfer(input logic [1:0] op, input logic [3:0] rg, input logic [7:0] wd);
        pm.frame(adr, op, rg, wd, rd, acks);
    endtask

    always @(posedge ref_clk) begin
        if (rst_n === 1'h1 && sda_oe === 1'h1) check({7'h00, sda_o}, 8'h00);
        if (rst_n === 1'h1 && pins.scl === 1'h1 && scl_prev === 1'h1) check({7'h00, sda_oe}, {7'h00, oe_prev});
        oe_prev  <= sda_oe;
        scl_prev <= pins.scl;
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_recall();
        for (int ch = 0; ch < qwc_pkg::NUM_CH; ch++) check(wo[ch], qwc_pkg::STORE_RESET);
        $display("test recall done");
    endtask

    task automatic t_bus();
        xfer(qwc_pkg::OP_WR_WIPER, 4'h4, 8'h3C);
        check({4'h0, acks}, 8'h00);
        check(wo[1], 8'h3C);
        check(wo[0], qwc_pkg::STORE_RESET);
        xfer(qwc_pkg::OP_RD_WIPER, 4'h4, 8'h00);
        check(rd, 8'h3C);
        check({4'h0, acks}, 8'h01);
        adr = adr ^ 8'h04;
        xfer(qwc_pkg::OP_WR_WIPER, 4'h4, 8'h11);
        check({4'h0, acks}, 8'h0F);
        check(wo[1], 8'h3C);
        adr = adr ^ 8'h04;
        $display("test bus done");
    endtask

    task automatic t_store();
        pm.set_cfg(1'h1, 3'h5);
        xfer(qwc_pkg::OP_WR_STORE, 4'h9, 8'h5A);
        xfer(qwc_pkg::OP_RD_STORE, 4'h9, 8'h00);
        check(rd, 8'h5A);
        pm.set_cfg(1'h0, 3'h5);
        xfer(qwc_pkg::OP_WR_STORE, 4'h9, 8'h11);
        check({4'h0, acks}, 8'h00);
        xfer(qwc_pkg::OP_RD_STORE, 4'h9, 8'h00);
        check(rd, 8'h5A);
        $display("test store done");
    endtask

    task automatic t_updown();
        pm.steps(1'h1, 2'h2, 3, 1'h0);
        check(wo[2], 8'h83);
        check(wo[3], qwc_pkg::STORE_RESET);
        pm.steps(1'h0, 2'h2, 1, 1'h0);
        check(wo[2], 8'h82);
        xfer(qwc_pkg::OP_WR_WIPER, 4'hC, 8'hFE);
        pm.steps(1'h1, 2'h3, 3, 1'h0);
        check(wo[3], qwc_pkg::WIPER_MAX);
        xfer(qwc_pkg::OP_WR_WIPER, 4'h0, 8'h01);
        pm.steps(1'h0, 2'h0, 3, 1'h0);
        check(wo[0], qwc_pkg::WIPER_MIN);
        $display("test updown done");
    endtask

    task automatic t_ignore();
        pm.ud_hold(1'h1);
        xfer(qwc_pkg::OP_WR_WIPER, 4'h4, 8'h77);
        check({4'h0, acks}, 8'h0F);
        check(wo[1], 8'h3C);
        check(wo[0], qwc_pkg::WIPER_MIN);
        pm.ud_hold(1'h0);
        xfer(qwc_pkg::OP_RD_STORE, 4'h0, 8'h00);
        check(rd, qwc_pkg::STORE_RESET);
        pm.set_cfg(1'h1, 3'h5);
        pm.steps(1'h1, 2'h2, 1, 1'h1);
        xfer(qwc_pkg::OP_RD_STORE, 4'h8, 8'h00);
        check(rd, 8'h83);
        $display("test ignore and store done");
    endtask

    initial begin
        fails    = 0;
        n_checks = 0;
        rst_n    = 1'h0;
        oe_prev  = 1'h0;
        scl_prev = 1'h1;
        adr      = {qwc_pkg::ADDR_ID_HI, 3'h5};
        pm.set_cfg(1'h1, 3'h5);
        repeat (12) @(posedge ref_clk);
        check(wo[0], qwc_pkg::WIPER_RESET);
        rst_n <= 1'h1;
        repeat (6) @(posedge ref_clk);
        t_recall();
        t_bus();
        t_store();
        t_updown();
        t_ignore();
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        $display("MISMATCH at %0t: run did not finish", $time);
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
